/* p6io_pkg.sv */
package p6io_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [15:0] DATA_LATCH_OFFS = 16'hffd9;
  localparam logic [15:0] PULLUP_EN_OFFS = 16'hffe3;
  localparam logic [15:0] DIRECTION_OFFS = 16'hffe9;

  // ****************************************
  // reset and fixed read values
  // ****************************************
  localparam logic [7:0] DATA_LATCH_RST = 8'h00;
  localparam logic [7:0] PULLUP_EN_RST = 8'h00;
  localparam logic [7:0] DIRECTION_RST = 8'h00;
  localparam logic [7:0] DIRECTION_READ = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] PIN_OUT_RST = 8'h00;
  localparam logic [7:0] PIN_OE_N_RST = 8'hff;
  localparam logic [7:0] PULLUP_OUT_RST = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;

  // ****************************************
  // operating modes, one-hot
  // ****************************************
  typedef enum logic [5:0] {
    MODE_ACTIVE = 6'h01,
    MODE_SUBACTIVE = 6'h02,
    MODE_SLEEP = 6'h04,
    MODE_SUBSLEEP = 6'h08,
    MODE_STANDBY = 6'h10,
    MODE_WATCH = 6'h20
  } p6io_mode_type;

  // ****************************************
  // drive-select decode
  // ****************************************
  // general-purpose for 00** and 010*, lcd drive for 011* and 1***
  function automatic logic p6io_is_gpio(input logic [3:0] sel);
    p6io_is_gpio = (sel[3] == 1'b0) && (sel[2:1] != 2'b11);
  endfunction

endpackage

/* p6io_sync.sv */
`timescale 1ns/1ps
module p6io_sync (
  input wire logic core_clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [7:0] async_i, // raw pin levels
  output logic [7:0] sync_o // filtered, synchronised levels
);

  logic [7:0] stage1_r;
  logic [7:0] stage2_r;
  logic [7:0] stage3_r;
  logic [7:0] sync_r;
  logic [7:0] agree;
  logic [7:0] sync_nxt;

  // ****************************************
  // agreement filter
  // ****************************************
  assign agree = ~(stage2_r ^ stage3_r);
  assign sync_nxt = (agree & stage3_r) | (~agree & sync_r);
  assign sync_o = sync_r;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1_r <= p6io_pkg::SYNC_RST;
      stage2_r <= p6io_pkg::SYNC_RST;
      stage3_r <= p6io_pkg::SYNC_RST;
      sync_r <= p6io_pkg::SYNC_RST;
    end else begin
      stage1_r <= async_i;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      sync_r <= sync_nxt;
    end
  end

endmodule

/* p6io_pin_mux.sv */
`timescale 1ns/1ps
module p6io_pin_mux (
  input wire logic [5:0] mode_i, // operating mode, one-hot
  input wire logic [3:0] drive_select_i, // pin function field
  input wire logic [7:0] direction_i, // direction bits
  input wire logic [7:0] latch_i, // output data latch
  input wire logic [7:0] pullup_en_i, // pull-up enable bits
  input wire logic [7:0] lcd_seg_i, // lcd drive levels
  output logic hold_o, // keep pins as they are
  output logic [7:0] drive_o, // next pin level
  output logic [7:0] oe_n_o, // next enable, low drives
  output logic [7:0] pullup_o // next pull-up state
);

  logic gpio;
  logic run;
  logic float;
  logic [7:0] pull_req;

  // ****************************************
  // pin function and mode decode
  // ****************************************
  assign gpio = p6io_pkg::p6io_is_gpio(drive_select_i);
  assign run = (mode_i == p6io_pkg::MODE_ACTIVE) || (mode_i == p6io_pkg::MODE_SUBACTIVE);
  assign hold_o = (mode_i == p6io_pkg::MODE_SLEEP) || (mode_i == p6io_pkg::MODE_SUBSLEEP);
  assign float = !run && !hold_o;
  // settings only count for general-purpose pins
  assign pull_req = gpio ? (pullup_en_i & ~direction_i) : 8'h00;
  assign drive_o = gpio ? latch_i : lcd_seg_i;
  assign oe_n_o = float ? 8'hff : (gpio ? ~direction_i : 8'h00);
  assign pullup_o = pull_req;

endmodule

/* p6io_port.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// - one latch bit per pin holds that pin's output value
// - port read of an output pin returns the latch bit
// - port read of an input pin returns the sampled pin level
// - reset clears the data latch to zero
// - direction 1 drives the pin, direction 0 makes it input
// - direction and latch only drive general-purpose pins; port reads use them for every pin
// - select 00** or 010* is general-purpose, 011* or 1*** is lcd drive
// - reset clears all direction bits, every pin is input
// - direction register is write-only and reads as all ones
// - pull-up on only for input pin with its enable set
// - reset clears all pull-up enables
// - hold in sleeps; run in active and subactive; float in reset and every other mode
// - enabled pull-ups still pull high in standby and watch
module p6io_port (
  input wire logic core_clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [15:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  input wire logic [5:0] mode_i, // operating mode, one-hot
  input wire logic [3:0] drive_select_i, // pin function field
  input wire logic [7:0] lcd_seg_i, // lcd drive levels
  input wire logic [7:0] port_six_pin_i, // pin levels in
  output logic [7:0] port_six_pin_o, // pin levels out
  output logic [7:0] port_six_pin_oe_n_o, // pin enables, low drives
  output logic [7:0] pullup_en_o // weak pull-up switches
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] port_six_data_latch_r;
  logic [7:0] port_six_direction_reg_r;
  logic [7:0] port_six_pullup_enable_reg_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] pin_r;
  logic [7:0] pin_nxt;
  logic [7:0] oe_n_r;
  logic [7:0] oe_n_nxt;
  logic [7:0] pullup_r;
  logic [7:0] pullup_nxt;
  logic [7:0] pin_sync;
  logic [7:0] port_view;
  logic hold;
  logic hit_data;
  logic hit_dir;
  logic hit_pull;
  logic wr_data;
  logic wr_dir;
  logic wr_pull;
  logic gpio;

  // ****************************************
  // pin input synchroniser
  // ****************************************
  p6io_sync p6io_sync_inst (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .async_i(port_six_pin_i),
    .sync_o(pin_sync)
  );

  // ****************************************
  // pin function and mode mux
  // ****************************************
  p6io_pin_mux p6io_pin_mux_inst (
    .mode_i(mode_i),
    .drive_select_i(drive_select_i),
    .direction_i(port_six_direction_reg_r),
    .latch_i(port_six_data_latch_r),
    .pullup_en_i(port_six_pullup_enable_reg_r),
    .lcd_seg_i(lcd_seg_i),
    .hold_o(hold),
    .drive_o(pin_nxt),
    .oe_n_o(oe_n_nxt),
    .pullup_o(pullup_nxt)
  );

  // ****************************************
  // address decode
  // ****************************************
  assign hit_data = (addr_i == p6io_pkg::DATA_LATCH_OFFS);
  assign hit_dir = (addr_i == p6io_pkg::DIRECTION_OFFS);
  assign hit_pull = (addr_i == p6io_pkg::PULLUP_EN_OFFS);
  assign wr_data = wr_i && hit_data;
  assign wr_dir = wr_i && hit_dir;
  assign wr_pull = wr_i && hit_pull;
  assign gpio = p6io_pkg::p6io_is_gpio(drive_select_i);

  // ****************************************
  // read path
  // ****************************************
  // output pins read the latch, input pins read the synchronised level
  assign port_view = (port_six_direction_reg_r & port_six_data_latch_r) |
                     (~port_six_direction_reg_r & pin_sync);
  assign rdata_nxt = !rd_i ? rdata_r :
                     hit_data ? port_view :
                     hit_dir ? p6io_pkg::DIRECTION_READ :
                     hit_pull ? port_six_pullup_enable_reg_r :
                     p6io_pkg::UNMAPPED_READ;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_six_data_latch_r <= p6io_pkg::DATA_LATCH_RST;
      port_six_direction_reg_r <= p6io_pkg::DIRECTION_RST;
      port_six_pullup_enable_reg_r <= p6io_pkg::PULLUP_EN_RST;
    end else begin
      if (wr_data) begin
        port_six_data_latch_r <= wdata_i;
      end
      if (wr_dir) begin
        port_six_direction_reg_r <= wdata_i;
      end
      if (wr_pull) begin
        port_six_pullup_enable_reg_r <= wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= p6io_pkg::UNMAPPED_READ;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // pins float during reset; sleep modes freeze them
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_r <= p6io_pkg::PIN_OUT_RST;
      oe_n_r <= p6io_pkg::PIN_OE_N_RST;
      pullup_r <= p6io_pkg::PULLUP_OUT_RST;
    end else if (!hold) begin
      pin_r <= pin_nxt;
      oe_n_r <= oe_n_nxt;
      pullup_r <= pullup_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign port_six_pin_o = pin_r;
  assign port_six_pin_oe_n_o = oe_n_r;
  assign pullup_en_o = pullup_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_latch_write: assert property (
    wr_data |=> port_six_data_latch_r == $past(wdata_i)
  ) else $error("data latch did not take the written value");

  chk_read_output: assert property (
    rd_i && hit_data |=> ((rdata_o ^ $past(port_six_data_latch_r)) & $past(port_six_direction_reg_r)) == 8'h00
  ) else $error("output pin read did not return latch");

  chk_read_input: assert property (
    rd_i && hit_data |=> ((rdata_o ^ $past(pin_sync)) & ~$past(port_six_direction_reg_r)) == 8'h00
  ) else $error("input pin read did not return pin level");

  chk_reset_clear: assert property (
    $rose(resetn_i) |-> port_six_data_latch_r == 8'h00 && port_six_direction_reg_r == 8'h00 &&
      port_six_pullup_enable_reg_r == 8'h00 && port_six_pin_oe_n_o == 8'hff
  ) else $error("registers not cleared by reset");

  chk_gpio_drive: assert property (
    mode_i == p6io_pkg::MODE_ACTIVE && gpio |=>
      port_six_pin_oe_n_o == ~$past(port_six_direction_reg_r) && port_six_pin_o == $past(port_six_data_latch_r)
  ) else $error("general-purpose pin drive wrong");

  chk_lcd_drive: assert property (
    mode_i == p6io_pkg::MODE_SUBACTIVE && !gpio |=>
      port_six_pin_oe_n_o == 8'h00 && port_six_pin_o == $past(lcd_seg_i) && pullup_en_o == 8'h00
  ) else $error("lcd drive pin wrong");

  chk_dir_read_ones: assert property (
    rd_i && hit_dir |=> rdata_o == 8'hff
  ) else $error("direction register did not read as ones");

  chk_pullup_gate: assert property (
    mode_i == p6io_pkg::MODE_ACTIVE && gpio |=>
      pullup_en_o == ($past(port_six_pullup_enable_reg_r) & ~$past(port_six_direction_reg_r))
  ) else $error("pull-up enable wrong");

  chk_standby_float: assert property (
    (mode_i == p6io_pkg::MODE_STANDBY || mode_i == p6io_pkg::MODE_WATCH) && gpio |=>
      port_six_pin_oe_n_o == 8'hff &&
      pullup_en_o == ($past(port_six_pullup_enable_reg_r) & ~$past(port_six_direction_reg_r))
  ) else $error("standby pins not floating with pull-ups");

  chk_sleep_hold: assert property (
    (mode_i == p6io_pkg::MODE_SLEEP || mode_i == p6io_pkg::MODE_SUBSLEEP) |=>
      $stable(port_six_pin_o) && $stable(port_six_pin_oe_n_o) && $stable(pullup_en_o)
  ) else $error("pins changed during sleep");

  chk_sync_settle: assert property (
    $stable(port_six_pin_i) [*5] |-> pin_sync == port_six_pin_i
  ) else $error("synchronised level did not settle");

endmodule

/* p6io_board.sv */
`timescale 1ns/1ps
module p6io_board (
  input wire logic core_clk_i, // system clock
  input wire logic [7:0] pin_o_i, // device drive levels
  input wire logic [7:0] oe_n_i, // device enables, low drives
  input wire logic [7:0] pullup_i, // device weak pull-ups
  input wire logic [7:0] ext_val_i, // board source levels
  input wire logic [7:0] ext_en_i, // board source enables
  output logic [7:0] level_o // resolved pin levels
);
  // ****************************************
  // wire resolution
  // ****************************************
  logic [7:0] float_r = 8'h5a;
  // an undriven pin without pull-up wanders every cycle
  always @(posedge core_clk_i) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) level_o[i] = pin_o_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pullup_i[i]) level_o[i] = 1'b1;
      else level_o[i] = float_r[i];
    end
  end
endmodule

/* tb_p6io_port.sv */
`timescale 1ns/1ps
module tb_p6io_port;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, lcd = 8'h00, ext = 8'h3c, ext_en = 8'hff, rdata, pin_o, oe_n, pu_o, lvl, hold_v;
  logic [7:0] dir, lat, pu, q[$];
  logic [5:0] mode = 6'h01;
  logic [3:0] sel = 4'h0;
  int seed = 55, num_errors = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  p6io_port p6io_port_inst (.core_clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .mode_i(mode), .drive_select_i(sel), .lcd_seg_i(lcd), .port_six_pin_i(lvl),
    .port_six_pin_o(pin_o), .port_six_pin_oe_n_o(oe_n), .pullup_en_o(pu_o));
  p6io_board p6io_board_inst (.core_clk_i(clk), .pin_o_i(pin_o), .oe_n_i(oe_n), .pullup_i(pu_o),
    .ext_val_i(ext), .ext_en_i(ext_en), .level_o(lvl));
  // ****************************************
  // checking
  // ****************************************
  // codes 00** and 010* keep the pin general-purpose
  function automatic logic gp_sel(input logic [3:0] s);
    return (s[3:2] == 2'b00) || (s[3:1] == 3'b010);
  endfunction
  task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      if (q.size() == 0) chk_byte("rdata_unexpected", 8'h00, 8'hxx);
      else chk_byte("rdata", q.pop_front(), rdata);
    end
  end
  initial begin
    #(25 * 90000);
    num_errors++;
    test_done();
  end
  // ****************************************
  // bus and pin tasks
  // ****************************************
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    q.push_back(exp);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk_pins(input logic stby);
    logic gp;
    logic [7:0] d;
    gp = gp_sel(sel);
    d = gp ? dir : 8'hff;
    chk_byte("oe_n", stby ? 8'hff : ~d, oe_n);
    if (!stby) chk_byte("pin_out", gp ? (lat & dir) : lcd, pin_o & d);
    chk_byte("pullup", gp ? (pu & ~dir) : 8'h00, pu_o);
  endtask
  task automatic set_regs();
    wr_reg(p6io_pkg::DATA_LATCH_OFFS, lat);
    wr_reg(p6io_pkg::DIRECTION_OFFS, dir);
    wr_reg(p6io_pkg::PULLUP_EN_OFFS, pu);
  endtask
  task automatic after_reset();
    dir = 8'h00;
    lat = 8'h00;
    pu = 8'h00;
    settle(3);
    chk_pins(1'b0);
    rd_reg(p6io_pkg::DATA_LATCH_OFFS, ext);
    rd_reg(p6io_pkg::PULLUP_EN_OFFS, 8'h00);
    rd_reg(p6io_pkg::DIRECTION_OFFS, 8'hff);
    rd_reg(16'h1234, p6io_pkg::UNMAPPED_READ);
    wr_reg(p6io_pkg::DIRECTION_OFFS, 8'hff);
    dir = 8'hff;
    rd_reg(p6io_pkg::DATA_LATCH_OFFS, 8'h00);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk_byte("oe_n_reset", 8'hff, oe_n);
    resetn <= 1'b1;
    after_reset();
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      {dir, lat, pu} = 24'($random(seed));
      ext <= 8'($random(seed));
      // input pins without their pull-up on get the board source enabled, so their level is known
      ext_en <= 8'($random(seed)) | ~(pu & ~dir);
      sel <= 4'($random(seed));
      lcd <= 8'($random(seed));
      mode <= i[0] ? 6'h02 : 6'h01;
      set_regs();
      settle(4);
      chk_pins(1'b0);
      rd_reg(p6io_pkg::DATA_LATCH_OFFS,
        (dir & lat) | (~dir & (gp_sel(sel) ? (ext | ~ext_en) : lcd)));
      rd_reg(p6io_pkg::PULLUP_EN_OFFS, pu);
      rd_reg(p6io_pkg::DIRECTION_OFFS, 8'hff);
    end
    $display("test random access done");
    ext_en <= 8'hff;
    for (int s = 0; s < 16; s++) begin
      @(posedge clk);
      sel <= s[3:0];
      lcd <= 8'($random(seed));
      settle(2);
      chk_pins(1'b0);
    end
    $display("test drive select done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      sel <= 4'h2;
      mode <= m[0] ? 6'h20 : 6'h10;
      settle(2);
      chk_pins(1'b1);
      @(posedge clk);
      mode <= m[0] ? 6'h08 : 6'h04;
      settle(2);
      hold_v = pin_o;
      {lat, dir} = {~lat, ~dir};
      set_regs();
      settle(2);
      chk_byte("pin_hold", hold_v, pin_o);
      @(posedge clk);
      mode <= 6'h01;
      settle(2);
      chk_pins(1'b0);
    end
    $display("test modes done");
    @(posedge clk);
    resetn <= 1'b0;
    settle(2);
    chk_byte("oe_n_reset", 8'hff, oe_n);
    chk_byte("pullup_reset", 8'h00, pu_o);
    resetn <= 1'b1;
    after_reset();
    settle(2);
    chk_byte("queue_empty", 8'h00, 8'(q.size()));
    $display("test second reset done");
    test_done();
  end
endmodule
